/* sim/peripheral_irq_enable_flags_test.sv */
// register-level test of the peripheral interrupt enable/flag block
`timescale 1ns/1ps
module peripheral_irq_enable_flags_test
  import pief_pkg::*;
;
  logic        aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, capcmp_mode;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, periph_irq_req, irq;
  logic        conv_done, serial_done, capture_evt, compare_evt, period_match, wide_timer_ovf;
  logic [5:0]  trig;
  logic [3:0]  strb;
  int          fails, n_compared;
  // event table: trigger index (7 means clear flags by a write), mode, expected flags
  int          ev_ix [14] = '{2, 3, 3, 2, 7, 2, 3, 7, 2, 3, 5, 4, 1, 0};
  logic [1:0]  ev_md [14] = '{0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 0, 0, 0, 0};
  logic [7:0]  ev_fl [14] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00,
                              8'h40, 8'h48, 8'h4A, 8'h4B};
  logic [7:0]  core_v [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};

  pief_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .conv_done(conv_done),
    .serial_done(serial_done), .capture_evt(capture_evt), .compare_evt(compare_evt),
    .capcmp_mode(capcmp_mode), .period_match(period_match), .wide_timer_ovf(wide_timer_ovf),
    .periph_irq_req(periph_irq_req), .irq(irq));

  pief_periph_model PERIPH (.aclk(aclk), .trig(trig), .wide_timer_ovf(wide_timer_ovf),
    .period_match(period_match), .capture_evt(capture_evt), .compare_evt(compare_evt),
    .serial_done(serial_done), .conv_done(conv_done));

  task automatic final_report();
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  // handshakes are judged at the falling edge, where ready/valid have settled, and acted on at the rising edge
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic awt, wt, bt;
    int   n;
    awaddr <= a; wdata <= {24'h0, d}; wstrb <= strb;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    bt = 1'b0; n = 0;
    while (!bt && n < 50) begin
      @(negedge aclk);
      awt = awvalid && awready; wt = wvalid && wready; bt = (bvalid === 1'b1);
      if (bt) chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
      if (awt) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      n++;
    end
    if (!bt) fails++;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    logic art, rt;
    int   n;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    rt = 1'b0; n = 0;
    while (!rt && n < 50) begin
      @(negedge aclk);
      art = arvalid && arready; rt = (rvalid === 1'b1);
      if (rt) begin
        chk({30'h0, rresp}, {30'h0, er});
        chk(rdata, {24'h000000, e});
      end
      @(posedge aclk);
      if (art) arvalid <= 1'b0;
      n++;
    end
    if (!rt) fails++;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // one peripheral pulse, then let the flag land before anything reads it
  task automatic fire(input int ix);
    trig <= 6'h01 << ix;
    @(posedge aclk);
    trig <= 6'h00;
    repeat (3) @(posedge aclk);
  endtask

  task automatic chk_out(input logic e_req, input logic e_irq);
    @(negedge aclk);
    chk({30'h0, irq, periph_irq_req}, {30'h0, e_irq, e_req});
    @(posedge aclk);
  endtask

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // a hung handshake must still end the run with a verdict
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    final_report();
  end

  initial begin
    aresetn = 1'b0; awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    capcmp_mode = 2'h0; trig = 6'h00; fails = 0; n_compared = 0; strb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(ADDR_FLAGS, 8'h00, RESP_OKAY);
    axi_rd(ADDR_ENABLES, 8'h00, RESP_OKAY);
    axi_wr(ADDR_ENABLES, 8'hFF, RESP_OKAY);
    axi_rd(ADDR_ENABLES, 8'h4F, RESP_OKAY);
    axi_wr(ADDR_FLAGS, 8'hFF, RESP_OKAY);
    axi_rd(ADDR_FLAGS, 8'h4F, RESP_OKAY);
    axi_wr(ADDR_FLAGS, 8'h00, RESP_OKAY);
    axi_wr(ADDR_ENABLES, 8'h00, RESP_OKAY);
    // a write without byte lane 0 leaves the register alone
    strb = 4'hE;
    axi_wr(ADDR_ENABLES, 8'h4F, RESP_OKAY);
    strb = 4'hF;
    axi_rd(ADDR_ENABLES, 8'h00, RESP_OKAY);
    // flags latch with every enable and the global enable off
    for (int i = 0; i < 14; i++) begin
      capcmp_mode <= ev_md[i];
      if (ev_ix[i] == 7) axi_wr(ADDR_FLAGS, 8'h00, RESP_OKAY);
      else fire(ev_ix[i]);
      axi_rd(ADDR_FLAGS, ev_fl[i], RESP_OKAY);
    end
    capcmp_mode <= 2'h0;
    chk_out(1'b0, 1'b0);
    repeat (20) @(posedge aclk);
    axi_rd(ADDR_FLAGS, 8'h4B, RESP_OKAY);
    // software clears stale flags before it enables anything
    axi_wr(ADDR_FLAGS, 8'h00, RESP_OKAY);
    axi_wr(ADDR_ENABLES, 8'h4F, RESP_OKAY);
    fire(1);
    for (int i = 0; i < 4; i++) begin
      axi_wr(ADDR_CORE, core_v[i], RESP_OKAY);
      chk_out(core_v[i] == 8'hC0, 1'b0);
    end
    axi_wr(ADDR_ENABLES, 8'h4D, RESP_OKAY);
    chk_out(1'b0, 1'b0);
    axi_wr(ADDR_ENABLES, 8'h02, RESP_OKAY);
    chk_out(1'b1, 1'b0);
    // a fresh period match with every gate open keeps the request up
    fire(1);
    chk_out(1'b1, 1'b0);
    // the request edge is latched in status and reaches irq only through the mask
    axi_rd(ADDR_ISR, 8'h01, RESP_OKAY);
    axi_wr(ADDR_IMR, 8'h01, RESP_OKAY);
    chk_out(1'b1, 1'b1);
    axi_wr(ADDR_ISR, 8'h01, RESP_OKAY);
    chk_out(1'b1, 1'b0);
    axi_wr(12'h100, 8'h00, RESP_SLVERR);
    axi_rd(12'h100, 8'h00, RESP_SLVERR);
    axi_rd(ADDR_ISR, 8'h02, RESP_OKAY);
    axi_wr(ADDR_IMR, 8'h02, RESP_OKAY);
    chk_out(1'b1, 1'b1);
    axi_wr(ADDR_ISR, 8'h02, RESP_OKAY);
    chk_out(1'b1, 1'b0);
    axi_wr(ADDR_FLAGS, 8'h00, RESP_OKAY);
    chk_out(1'b0, 1'b0);
    final_report();
  end
endmodule // peripheral_irq_enable_flags_test

/* sim/pief_periph_model.sv */
// behavioural model of the on-chip peripherals that raise condition pulses
`timescale 1ns/1ps
module pief_periph_model #(
  parameter bit HAS_CONV = 1'b1
) (
  input  wire logic       aclk,
  input  wire logic [5:0] trig,
  output logic            wide_timer_ovf,
  output logic            period_match,
  output logic            capture_evt,
  output logic            compare_evt,
  output logic            serial_done,
  output logic            conv_done
);
  // one clean pulse per request, launched just after the edge like real logic
  always @(posedge aclk) begin
    wide_timer_ovf <= trig[0];
    period_match   <= trig[1];
    capture_evt    <= trig[2];
    compare_evt    <= trig[3];
    serial_done    <= trig[4];
    // a part without converter never raises its pulse, so its bit stays clear
    conv_done      <= HAS_CONV & trig[5];
  end
endmodule // pief_periph_model

/* verilog/pief_flag_core.sv */
// flag and enable registers with the gated peripheral request
`timescale 1ns/1ps
module pief_flag_core
  import pief_pkg::*;
#(
  parameter bit HAS_CONV = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  pief_reg_if.core rf
);

  // without a converter its bit position is reserved and held at zero
  localparam logic [7:0] KEEP = HAS_CONV ? IMPL_MASK : (IMPL_MASK & ~CONV_MASK);

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] enables;
  } pief_core_st_t;

  pief_core_st_t st_r;
  pief_core_st_t st_nxt;

  // software write first, then hardware sets on top so a set is never lost
  always_comb begin
    st_nxt = st_r;
    if (rf.wr_enables) begin
      st_nxt.enables = rf.wdata & KEEP; // [RL1] [RL2]
    end
    if (rf.wr_flags) begin
      st_nxt.flags = rf.wdata & KEEP; // [RL3]
    end
    st_nxt.flags = st_nxt.flags | (rf.set_evt & KEEP); // [RL4]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r.flags   <= RST_BYTE; // [RL3]
      st_r.enables <= RST_BYTE; // [RL2]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rf.flags   = st_r.flags;
  assign rf.enables = st_r.enables;
  // request needs flag, enable, master and global enable all set
  assign rf.req = rf.global_en & rf.master_en & (|(st_r.flags & st_r.enables)); // [RL13] [RL14] [RL15]

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_enable_store: assert property (rf.wr_enables |=> rf.enables == ($past(rf.wdata) & KEEP)) // [RL2]
    else $error("enable register did not take the written value");
  a_set_wins_clear: assert property ((rf.wr_flags && (rf.set_evt & KEEP) != 8'h00) |=>
      ((rf.flags & $past(rf.set_evt) & KEEP) == ($past(rf.set_evt) & KEEP))) // [RL4]
    else $error("flag set lost against a same-cycle clear");

endmodule // pief_flag_core

/* verilog/pief_pkg.sv */
// shared constants for the peripheral interrupt enable/flag block
package pief_pkg;

  // register byte addresses on the AXI4-Lite slave
  localparam logic [11:0] ADDR_FLAGS   = 12'h00C;
  localparam logic [11:0] ADDR_ENABLES = 12'h08C;
  localparam logic [11:0] ADDR_CORE    = 12'h010;
  localparam logic [11:0] ADDR_ISR     = 12'h014;
  localparam logic [11:0] ADDR_IMR     = 12'h018;

  // bit positions shared by the flag and enable registers
  localparam int BIT_CONV   = 6;
  localparam int BIT_SER    = 3;
  localparam int BIT_CAPCMP = 2;
  localparam int BIT_PERIOD = 1;
  localparam int BIT_WOVF   = 0;

  // implemented bits; 7, 5 and 4 always read zero
  localparam logic [7:0] IMPL_MASK = 8'h4F;
  localparam logic [7:0] CONV_MASK = 8'h40;
  localparam logic [7:0] RST_BYTE  = 8'h00;

  // core interrupt control: global enable bit 7, peripheral master bit 6
  localparam int         BIT_GLOBAL = 7;
  localparam int         BIT_MASTER = 6;
  localparam logic [7:0] CORE_MASK  = 8'hC0;

  // block interrupt status: request rising edge, bad register access
  localparam int         ISR_REQ  = 0;
  localparam int         ISR_BAD  = 1;
  localparam logic [7:0] ISR_MASK = 8'h03;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // operating mode reported by the capture/compare unit
  typedef enum logic [1:0] {
    CCM_OFF,
    CCM_CAPTURE,
    CCM_COMPARE,
    CCM_PWM
  } pief_ccm_t;

endpackage

/* verilog/pief_reg_if.sv */
// carrier between the bus front end and the flag/enable core
`timescale 1ns/1ps
interface pief_reg_if;
  logic [7:0] set_evt;
  logic [7:0] wdata;
  logic       wr_flags;
  logic       wr_enables;
  logic       master_en;
  logic       global_en;
  logic [7:0] flags;
  logic [7:0] enables;
  logic       req;

  modport core (
    input  set_evt, wdata, wr_flags, wr_enables, master_en, global_en,
    output flags, enables, req
  );
  modport ctrl (
    output set_evt, wdata, wr_flags, wr_enables, master_en, global_en,
    input  flags, enables, req
  );
endinterface

/* verilog/pief_top.sv */
// peripheral interrupt enable/flag block with AXI4-Lite register access
// What this block does
// RL1: an eight-bit enable register holds converter 6, serial 3, capcmp 2, period 1, timer overflow 0; 7,5,4 read 0.
// RL2: each enable bit passes its request at one and blocks it at zero, is read/write and resets to zero.
// RL3: an eight-bit flag register mirrors the enable bit positions, reads zero at 7,5,4 and resets to zero.
// RL4: a flag is set by its condition whatever its enable bit and the global enable say.
// RL5: the converter flag sets on conversion done and holds until software writes it to zero.
// RL6: the serial flag sets when a transfer completes and holds until software clears it.
// RL7: in capture mode the capcmp flag sets on a timer capture and holds until cleared.
// RL8: in compare mode the capcmp flag sets on a compare match and holds; in PWM mode it is not set.
// RL9: the period flag sets when the period timer equals its period value and holds until cleared.
// RL10: the overflow flag sets when the sixteen-bit timer overflows and holds until cleared.
// RL11: on a part without converter, software keeps the converter enable and flag at zero.
// RL12: software clears a flag before setting its enable so a stale event does not interrupt.
// RL13: no peripheral request reaches the core unless the peripheral master enable is set.
// RL14: the global enable passes unmasked interrupts when set and blocks all when clear; it gates periph_irq_req only, irq is not blocked.
// RL15: the request to the core is the OR of flag AND enable, gated by master and global enables.
`timescale 1ns/1ps
module pief_top
  import pief_pkg::*;
#(
  parameter int ADDR_W   = 12,
  parameter bit HAS_CONV = 1'b1
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output wire logic              awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output wire logic              wready,
  // AXI4-Lite write response
  output wire logic [1:0]        bresp,
  output wire logic              bvalid,
  input  wire logic              bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output wire logic              arready,
  // AXI4-Lite read data
  output wire logic [31:0]       rdata,
  output wire logic [1:0]        rresp,
  output wire logic              rvalid,
  input  wire logic              rready,
  // condition pulses from the on-chip peripherals
  input  wire logic              conv_done,
  input  wire logic              serial_done,
  input  wire logic              capture_evt,
  input  wire logic              compare_evt,
  input  wire logic [1:0]        capcmp_mode,
  input  wire logic              period_match,
  input  wire logic              wide_timer_ovf,
  // requests
  output wire logic              periph_irq_req,
  output wire logic              irq
);

  typedef struct packed {
    logic              aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;
    logic [7:0]        wdata;
    logic              wstb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
    logic [7:0]        core_ctl;
    logic [7:0]        isr;
    logic [7:0]        imr;
    logic              req_d;
  } pief_top_st_t;

  pief_top_st_t st_r;
  pief_top_st_t st_nxt;

  logic       do_wr;
  logic       ar_hs;
  logic       w_fl;
  logic       w_en;
  logic       w_core;
  logic       w_isr;
  logic       w_imr;
  logic       w_hit;
  logic [7:0] rd_val;
  logic       rd_hit;
  logic [7:0] isr_set;
  logic [7:0] isr_clr;
  logic [7:0] evt;

  pief_reg_if rif ();

  pief_flag_core #(
    .HAS_CONV (HAS_CONV)
  ) u_core (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rf      (rif)
  );

  // one write and one read in flight; channels stall while a response waits
  assign awready = !st_r.aw_got && !st_r.bvalid;
  assign wready  = !st_r.w_got && !st_r.bvalid;
  assign arready = !st_r.rvalid;
  assign do_wr   = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign ar_hs   = arvalid && arready;

  // write decode on the held address; misaligned addresses miss
  assign w_fl   = st_r.awaddr == ADDR_W'(ADDR_FLAGS);
  assign w_en   = st_r.awaddr == ADDR_W'(ADDR_ENABLES);
  assign w_core = st_r.awaddr == ADDR_W'(ADDR_CORE);
  assign w_isr  = st_r.awaddr == ADDR_W'(ADDR_ISR);
  assign w_imr  = st_r.awaddr == ADDR_W'(ADDR_IMR);
  assign w_hit  = w_fl | w_en | w_core | w_isr | w_imr;

  // read decode, registers live in lane 0 and upper bits read zero
  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case (araddr)
      ADDR_W'(ADDR_FLAGS):   rd_val = rif.flags; // [RL3]
      ADDR_W'(ADDR_ENABLES): rd_val = rif.enables; // [RL1]
      ADDR_W'(ADDR_CORE):    rd_val = st_r.core_ctl;
      ADDR_W'(ADDR_ISR):     rd_val = st_r.isr;
      ADDR_W'(ADDR_IMR):     rd_val = st_r.imr;
      default:               rd_hit = 1'b0;
    endcase
  end

  // map peripheral conditions to flag positions; capcmp follows its mode
  always_comb begin
    evt                 = 8'h00;
    evt[BIT_CONV]       = conv_done; // [RL5]
    evt[BIT_SER]        = serial_done; // [RL6]
    evt[BIT_CAPCMP]     = (pief_ccm_t'(capcmp_mode) == CCM_CAPTURE && capture_evt) || // [RL7]
                          (pief_ccm_t'(capcmp_mode) == CCM_COMPARE && compare_evt); // [RL8]
    evt[BIT_PERIOD]     = period_match; // [RL9]
    evt[BIT_WOVF]       = wide_timer_ovf; // [RL10]
  end

  // byte lane 0 strobe gates every register write
  assign rif.set_evt    = evt; // [RL4]
  assign rif.wdata      = st_r.wdata;
  assign rif.wr_flags   = do_wr && w_fl && st_r.wstb; // [RL5] [RL6] [RL9] [RL10]
  assign rif.wr_enables = do_wr && w_en && st_r.wstb; // [RL2]
  assign rif.global_en  = st_r.core_ctl[BIT_GLOBAL]; // [RL14]
  assign rif.master_en  = st_r.core_ctl[BIT_MASTER]; // [RL13]

  // sticky status events: new request edge, access to an unmapped word
  always_comb begin
    isr_set          = 8'h00;
    isr_set[ISR_REQ] = rif.req && !st_r.req_d;
    isr_set[ISR_BAD] = (do_wr && !w_hit) || (ar_hs && !rd_hit);
    isr_clr          = (do_wr && w_isr && st_r.wstb) ? st_r.wdata : 8'h00;
  end

  // next-state for the bus slave and the local control registers
  always_comb begin
    st_nxt = st_r;
    if (awvalid && awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = wdata[7:0];
      st_nxt.wstb  = wstrb[0];
    end
    if (do_wr) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = w_hit ? RESP_OKAY : RESP_SLVERR;
      if (w_core && st_r.wstb) begin
        st_nxt.core_ctl = st_r.wdata & CORE_MASK; // [RL13] [RL14]
      end
      if (w_imr && st_r.wstb) begin
        st_nxt.imr = st_r.wdata & ISR_MASK;
      end
    end else if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (ar_hs) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_val;
      st_nxt.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // set beats a same-cycle write-one clear
    st_nxt.isr   = ((st_r.isr & ~isr_clr) | isr_set) & ISR_MASK;
    st_nxt.req_d = rif.req;
  end

  // synchronous reset clears every field, control registers included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // every response output comes straight from a flop; upper read lanes are tied to zero
  assign bvalid         = st_r.bvalid;
  assign bresp          = st_r.bresp;
  assign rvalid         = st_r.rvalid;
  assign rresp          = st_r.rresp;
  assign rdata          = {24'h000000, st_r.rdata};
  assign periph_irq_req = rif.req; // [RL15]
  // level output, drops as soon as software clears the last unmasked bit
  assign irq = |(st_r.isr & st_r.imr);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reserved_zero: assert property (((rif.flags | rif.enables) & ~IMPL_MASK) == 8'h00) // [RL1] [RL3]
    else $error("reserved flag or enable bit reads non-zero");
  a_conv_sets: assert property ((HAS_CONV && conv_done) |=> rif.flags[BIT_CONV]) // [RL5]
    else $error("converter flag not set after conversion done");
  a_serial_sets: assert property (serial_done |=> rif.flags[BIT_SER]) // [RL6]
    else $error("serial flag not set after transfer done");
  a_capture_sets: assert property ((capcmp_mode == 2'(CCM_CAPTURE) && capture_evt) // [RL7]
      |=> rif.flags[BIT_CAPCMP])
    else $error("capcmp flag not set on capture");
  a_compare_sets: assert property ((capcmp_mode == 2'(CCM_COMPARE) && compare_evt) // [RL8]
      |=> rif.flags[BIT_CAPCMP])
    else $error("capcmp flag not set on compare match");
  a_pwm_no_set: assert property ((capcmp_mode == 2'(CCM_PWM) && !rif.flags[BIT_CAPCMP] // [RL8]
      && !rif.wr_flags) |=> !rif.flags[BIT_CAPCMP])
    else $error("capcmp flag set while in pwm mode");
  a_period_sets: assert property (period_match |=> rif.flags[BIT_PERIOD]) // [RL9]
    else $error("period flag not set on match");
  a_ovf_sets: assert property ((wide_timer_ovf && !rif.enables[BIT_WOVF]) |=> rif.flags[BIT_WOVF]) // [RL4] [RL10]
    else $error("overflow flag not set while disabled");
  a_flags_sticky: assert property (!rif.wr_flags |=> ((rif.flags & $past(rif.flags)) == $past(rif.flags))) // [RL5]
    else $error("flag dropped without a software write");
  a_req_blocked: assert property (!(st_r.core_ctl[BIT_GLOBAL] && st_r.core_ctl[BIT_MASTER]) // [RL13] [RL14]
      |-> !periph_irq_req)
    else $error("peripheral request passed a cleared enable");
  a_req_path: assert property ((period_match && rif.enables[BIT_PERIOD] && st_r.core_ctl[BIT_GLOBAL] // [RL15]
      && st_r.core_ctl[BIT_MASTER] && !do_wr) |=> periph_irq_req)
    else $error("enabled period match did not request");
  a_write_answer: assert property (do_wr |=> bvalid ##0 (bresp == (w_hit ? RESP_OKAY : RESP_SLVERR))[*1])
    else $error("write response missing after write");
  a_read_answer: assert property (ar_hs |=> rvalid && rdata[31:8] == 24'h000000) // [RL1] [RL3]
    else $error("read response missing or upper bits set");

  // unmapped words answer an error, and a read of one returns zero data
  a_read_unmapped: assert property ((ar_hs && !rd_hit) |=>
      (rresp == RESP_SLVERR) && (rdata == 32'h00000000))
    else $error("unmapped read not answered with an error and zero data");
  a_write_unmapped: assert property ((do_wr && !w_hit) |=> bvalid && (bresp == RESP_SLVERR))
    else $error("unmapped write not answered with an error");
  // a waiting response stalls its channel, so one access per direction is in flight
  a_write_stall: assert property (bvalid |-> (!awready && !wready))
    else $error("write channel ready while a response waits");
  a_read_stall: assert property (rvalid |-> !arready)
    else $error("read address ready while read data waits");

  // a software write stores implemented bits only; a same-cycle event is checked apart
  a_flag_write: assert property ((rif.wr_flags && rif.set_evt == 8'h00) |=> // [RL5] [RL9] [RL10]
      rif.flags == ($past(rif.wdata) & IMPL_MASK & (HAS_CONV ? 8'hFF : ~CONV_MASK)))
    else $error("flag register did not take the written value");
  a_capcmp_off: assert property ((capcmp_mode == 2'(CCM_OFF) && !rif.flags[BIT_CAPCMP] // [RL7] [RL8]
      && !rif.wr_flags) |=> !rif.flags[BIT_CAPCMP])
    else $error("capcmp flag set while the unit is off");
  a_enable_gates: assert property (((rif.flags & rif.enables) == 8'h00) |-> !periph_irq_req) // [RL2] [RL15]
    else $error("request raised with no enabled flag");
  a_core_write: assert property ((do_wr && w_core && st_r.wstb) |=> // [RL13] [RL14]
      st_r.core_ctl == ($past(st_r.wdata) & CORE_MASK))
    else $error("core control did not take the written value");

  // status latches request edges and bad accesses; only a write of one clears a bit
  a_edge_latched: assert property ($rose(periph_irq_req) |=> st_r.isr[ISR_REQ])
    else $error("request edge not latched in status");
  a_bad_latched: assert property (((do_wr && !w_hit) || (ar_hs && !rd_hit)) |=> st_r.isr[ISR_BAD])
    else $error("unmapped access not latched in status");
  a_status_sticky: assert property ((st_r.isr[ISR_REQ] && !(do_wr && w_isr && st_r.wstb))
      |=> st_r.isr[ISR_REQ])
    else $error("status bit dropped without a clear");

  // reset is checked without the default disable so that its own effect is seen
  a_reset_clears: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> // [RL2] [RL3]
      (rif.flags == 8'h00) && (rif.enables == 8'h00) && !bvalid && !rvalid && !irq)
    else $error("registers or responses not cleared by reset");

  c_flag_write: cover property (rif.wr_flags ##1 bvalid && bready);
  c_read_flags: cover property (ar_hs && araddr == ADDR_W'(ADDR_FLAGS) ##1 rvalid);
  c_irq_fires: cover property (periph_irq_req ##1 irq);
  c_set_vs_clear: cover property (rif.wr_flags && evt != 8'h00);
  c_bad_access: cover property (isr_set[ISR_BAD]);

endmodule // pief_top
